// ---- verilog/cbc_bus_ctl.sv ----
`timescale 1ns/10ps
// Contract
// - lower register area 0000h-01FFh: each byte cycle takes two clocks.
// - upper register area 0200h-02FFh: each byte cycle takes three clocks.
// - program ROM and RAM: one clock per byte cycle, no waits.
// - data flash area takes two clocks per byte cycle.
// - target data path is one byte wide.
// - word access becomes two byte cycles, each timed by its area.
// - only single-chip mode; only internal areas reachable.
// - word access: first cycle even address, second cycle address plus one; the controller does not force even, it uses cpu_addr as given.
module cbc_bus_ctl #(
   parameter logic [15:0] FLASH_BASE = 16'h3000,
   parameter logic [15:0] FLASH_LAST = 16'h37ff,
   parameter bit HAS_FLASH = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // cpu side
   input wire logic cpu_req,
   input wire logic cpu_we,
   input wire logic cpu_word,
   input wire logic [cbc_pkg::ADDR_W-1:0] cpu_addr,
   input wire logic [15:0] cpu_wdata,
   output logic cpu_wait,
   output logic cpu_done,
   output logic [15:0] cpu_rdata,
   // internal byte bus
   output logic [cbc_pkg::ADDR_W-1:0] tb_addr,
   output logic tb_sel,
   output logic tb_we,
   output logic [cbc_pkg::DATA_W-1:0] tb_wdata,
   output logic tb_last,
   input wire logic [cbc_pkg::DATA_W-1:0] tb_rdata
);
   import cbc_pkg::*;

   typedef enum logic [1:0] {
      CBC_IDLE,
      CBC_BYTE0,
      CBC_BYTE1
   } cbc_state_e;

   cbc_tgt_if tgt ();

   // sequencer
   cbc_state_e state;
   cbc_state_e next_state;
   logic first;
   logic next_first;
   // request, captured at the taking edge; addr steps by one for the second byte of a word
   logic [15:0] addr;
   logic [15:0] next_addr;
   logic [15:0] wdat;
   logic [15:0] next_wdat;
   logic word;
   logic next_word;
   logic we;
   logic next_we;
   // read assembly
   logic [7:0] lo;
   logic [7:0] next_lo;
   logic [15:0] rdata;
   logic [15:0] next_rdata;
   logic done;
   logic next_done;
   // decoded strobes
   logic busy;
   logic take;
   logic byte_end;
   logic word_split;
   logic access_end;

   cbc_wait_gen #(
      .FLASH_BASE(FLASH_BASE),
      .FLASH_LAST(FLASH_LAST),
      .HAS_FLASH(HAS_FLASH)
   ) u_wait (
      .ref_clk(ref_clk),
      .rst(rst),
      .tgt(tgt)
   );

   // request looked at only while idle, so one held through a stall is harmless
   assign busy = (state != CBC_IDLE);
   assign take = cpu_req && !busy;
   assign byte_end = busy && tgt.cyc_last;
   assign word_split = byte_end && (state == CBC_BYTE0) && word;
   assign access_end = byte_end && !word_split;

   always_comb begin
      next_state = state;
      next_first = 1'b0;
      unique case (state)
         CBC_IDLE: begin
            if (take) begin
               next_state = CBC_BYTE0;
               next_first = 1'b1;
            end
         end
         CBC_BYTE0: begin
            if (word_split) begin
               next_state = CBC_BYTE1;
               next_first = 1'b1;
            end else if (access_end) begin
               next_state = CBC_IDLE;
            end
         end
         CBC_BYTE1: begin
            if (access_end) begin
               next_state = CBC_IDLE;
            end
         end
         default: begin
            next_state = CBC_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state <= CBC_IDLE;
         first <= 1'b0;
      end else begin
         state <= next_state;
         first <= next_first;
      end
   end

   always_comb begin
      next_addr = addr;
      next_wdat = wdat;
      next_word = word;
      next_we = we;
      if (take) begin
         next_addr = cpu_addr;
         next_wdat = cpu_wdata;
         next_word = cpu_word;
         next_we = cpu_we;
      end else if (word_split) begin
         next_addr = addr + 16'h0001;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         addr <= 16'h0000;
         wdat <= 16'h0000;
         word <= 1'b0;
         we <= 1'b0;
      end else begin
         addr <= next_addr;
         wdat <= next_wdat;
         word <= next_word;
         we <= next_we;
      end
   end

   // target byte is valid only on the last clock of its cycle
   always_comb begin
      next_lo = lo;
      next_rdata = rdata;
      next_done = 1'b0;
      if (word_split) begin
         next_lo = tb_rdata;
      end
      if (access_end) begin
         next_done = 1'b1;
         if (word) begin
            next_rdata = {tb_rdata, lo}; // low byte first
         end else begin
            next_rdata = {8'h00, tb_rdata};
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lo <= 8'h00;
         rdata <= 16'h0000;
         done <= 1'b0;
      end else begin
         lo <= next_lo;
         rdata <= next_rdata;
         done <= next_done;
      end
   end

   assign tgt.addr = addr;
   assign tgt.cyc_start = first;

   // only internal areas exist; no external bus strobes at all
   assign tb_addr = addr;
   assign tb_sel = busy;
   assign tb_we = we && busy;
   assign tb_wdata = (state == CBC_BYTE1) ? wdat[15:8] : wdat[7:0];
   assign tb_last = byte_end;
   // stall covers the whole access, released with the done pulse
   assign cpu_wait = busy;
   assign cpu_done = done;
   assign cpu_rdata = rdata;
endmodule : cbc_bus_ctl

// ---- verilog/cbc_pkg.sv ----
package cbc_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam logic [15:0] SFR_LO_BASE = 16'h0000;
   localparam logic [15:0] SFR_LO_LAST = 16'h01ff;
   localparam logic [15:0] SFR_HI_BASE = 16'h0200;
   localparam logic [15:0] SFR_HI_LAST = 16'h02ff;
   localparam logic [1:0] CYC_SFR_LO = 2'h2;
   localparam logic [1:0] CYC_SFR_HI = 2'h3;
   localparam logic [1:0] CYC_MEM = 2'h1;
   localparam logic [1:0] CYC_FLASH = 2'h2;
   typedef enum logic [1:0] {
      CBC_AREA_SFR_LO,
      CBC_AREA_SFR_HI,
      CBC_AREA_FLASH,
      CBC_AREA_MEM
   } cbc_area_e;
endpackage : cbc_pkg

// ---- verilog/cbc_tgt_if.sv ----
`timescale 1ns/10ps
interface cbc_tgt_if;
   logic [15:0] addr;
   logic cyc_start;
   logic cyc_last;
   modport ctl (output addr, output cyc_start, input cyc_last);
   modport dec (input addr, input cyc_start, output cyc_last);
endinterface : cbc_tgt_if

// ---- verilog/cbc_wait_gen.sv ----
`timescale 1ns/10ps
module cbc_wait_gen #(
   parameter logic [15:0] FLASH_BASE = 16'h3000,
   parameter logic [15:0] FLASH_LAST = 16'h37ff,
   parameter bit HAS_FLASH = 1'b1
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // cycle timing
   cbc_tgt_if.dec tgt
);
   import cbc_pkg::*;

   logic [1:0] cnt;
   logic [1:0] next_cnt;
   logic [1:0] len;

   function automatic logic [1:0] area_len(input logic [15:0] a);
      if (a >= SFR_LO_BASE && a <= SFR_LO_LAST) return CYC_SFR_LO;
      if (a >= SFR_HI_BASE && a <= SFR_HI_LAST) return CYC_SFR_HI;
      if (HAS_FLASH && a >= FLASH_BASE && a <= FLASH_LAST) return CYC_FLASH;
      return CYC_MEM;
   endfunction : area_len

   always_comb begin
      len = area_len(tgt.addr);
      next_cnt = cnt;
      if (tgt.cyc_start) begin
         next_cnt = len - 2'h1;
      end else if (cnt != 2'h0) begin
         next_cnt = cnt - 2'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt <= 2'h0;
      end else begin
         cnt <= next_cnt;
      end
   end

   // last clock of the byte cycle: the counter is down to one, or a one-clock area on its first clock
   assign tgt.cyc_last = tgt.cyc_start ? (len == CYC_MEM) : (cnt == 2'h1);
endmodule : cbc_wait_gen

// ---- dv/cbc_tgt_model.sv ----
`timescale 1ns/10ps
module cbc_tgt_model (
   // clock
   input wire logic ref_clk,
   // byte bus
   input wire logic tb_last,
   input wire logic [15:0] tb_addr,
   output logic [7:0] tb_rdata
);
   logic flip = 1'b0;
   always_ff @(posedge ref_clk) flip <= !flip;
   // junk off the last clock, so early sampling shows
   assign tb_rdata = tb_last ? tb_addr[7:0] ^ 8'h5a : {8{flip}};
endmodule : cbc_tgt_model

// ---- dv/cbc_bus_ctl_sva.sv ----
`timescale 1ns/10ps
module cbc_bus_ctl_sva (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // watched
   input wire logic cpu_req,
   input wire logic cpu_wait,
   input wire logic cpu_done,
   input wire logic tb_sel,
   input wire logic tb_last,
   input wire logic [15:0] tb_addr
);
   logic mid;
   logic st;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   // past the first clock of a byte cycle
   always_ff @(posedge ref_clk) mid <= !rst && tb_sel && !tb_last;
   assign st = tb_sel && !mid;
   chk_lo_two: assert property (st && tb_addr <= 16'h01ff |-> !tb_last ##1 tb_last)
      else $error("low area length");
   chk_hi_three: assert property (st && tb_addr inside {[16'h0200:16'h02ff]} |->
      !tb_last [*2] ##1 tb_last) else $error("high area length");
   chk_mem_one: assert property (st && tb_addr > 16'h37ff |-> tb_last)
      else $error("memory length");
   chk_flash_two: assert property (st && tb_addr inside {[16'h3000:16'h37ff]} |->
      !tb_last ##1 tb_last) else $error("flash length");
   chk_word_addr: assert property (tb_last ##1 tb_sel |-> tb_addr == $past(tb_addr) + 16'h1)
      else $error("second byte address");
   chk_take_req: assert property (cpu_req && !cpu_wait |=> cpu_wait && tb_sel)
      else $error("request not taken");
   chk_done_end: assert property (tb_last ##1 !tb_sel |-> cpu_done && !cpu_wait)
      else $error("done late");
   chk_busy_wait: assert property (tb_sel |-> cpu_wait && !cpu_done)
      else $error("cpu not stalled");
endmodule : cbc_bus_ctl_sva
bind cbc_bus_ctl cbc_bus_ctl_sva i_sva (.ref_clk, .rst, .cpu_req, .cpu_wait, .cpu_done,
   .tb_sel, .tb_last, .tb_addr);

// ---- dv/cpu_bus_cycle_control_tb.sv ----
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
   $display("MISMATCH %0t %h %h", $time, a, b); end end
module cpu_bus_cycle_control_tb;
   import cbc_pkg::*;
   logic ref_clk = 0, rst = 1, cpu_req = 0, cpu_we = 0, cpu_word = 0;
   logic [15:0] cpu_addr = 0, cpu_wdata = 0, cpu_rdata, tb_addr;
   logic cpu_wait, cpu_done, tb_sel, tb_we, tb_last;
   logic [7:0] tb_wdata, tb_rdata;
   logic [24:0] exp_q[$];
   logic [24:0] e;
   logic [24:0] wr_q[$];
   logic [24:0] b;
   int err_count = 0, num_checks = 0, cnt = 0;
   logic [31:0] seed = 32'd89525;
   logic [15:0] tbl[8] = '{16'h0000, 16'h01ff, 16'h0200, 16'h02ff, 16'h0300, 16'h3000,
      16'h37ff, 16'h3800};
   cbc_bus_ctl i_dut (.ref_clk, .rst, .cpu_req, .cpu_we, .cpu_word, .cpu_addr, .cpu_wdata,
      .cpu_wait, .cpu_done, .cpu_rdata, .tb_addr, .tb_sel, .tb_we, .tb_wdata, .tb_last,
      .tb_rdata);
   cbc_tgt_model i_tgt (.ref_clk, .tb_last, .tb_addr, .tb_rdata);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [7:0] len(input logic [15:0] a);
      if (a <= SFR_LO_LAST) return 8'(CYC_SFR_LO);
      if (a <= SFR_HI_LAST) return 8'(CYC_SFR_HI);
      if (a >= 16'h3000 && a <= 16'h37ff) return 8'(CYC_FLASH);
      return 8'(CYC_MEM);
   endfunction : len
   // req stays high while busy, so a request taken again would show as extra work
   task automatic acc(input logic [15:0] a, input logic w);
      logic [31:0] r;
      logic [7:0] f;
      r = rnd();
      f = a[7:0] ^ 8'h5a;
      cpu_we = r[0];
      cpu_word = w;
      cpu_addr = a;
      cpu_wdata = r[31:16];
      cpu_req = 1;
      exp_q.push_back({len(a) + (w ? len(a + 16'h1) : 8'h0) + 8'h1, !r[0],
         w ? {f ^ 8'h01, f} : {8'h00, f}});
      wr_q.push_back({r[0], a, r[23:16]});
      if (w) wr_q.push_back({r[0], a + 16'h1, r[31:24]});
      @(posedge ref_clk);
      #1;
      while (cpu_done !== 1'b1) begin
         @(posedge ref_clk);
         #1;
      end
   endtask : acc
   task automatic wrap_up();
      if (err_count == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : wrap_up
   initial begin
      forever #20 ref_clk = !ref_clk;
   end
   always @(posedge ref_clk) begin
      if (cpu_done === 1'b1) begin
         e = exp_q.pop_front();
         `CHK(cnt[7:0], e[24:17])
         if (e[16]) `CHK(cpu_rdata, e[15:0])
      end
      if (tb_last === 1'b1) begin
         b = wr_q.pop_front();
         `CHK(tb_addr, b[23:8])
         `CHK(tb_we, b[24])
         if (b[24]) `CHK(tb_wdata, b[7:0])
      end
      // the taking edge counts as the first edge of the access
      cnt = (cpu_req && !cpu_wait) ? 1 : cnt + 1;
   end
   initial begin
      logic [15:0] a;
      logic w;
      repeat (3) @(posedge ref_clk);
      #1;
      rst = 0;
      for (int i = 0; i < 40; i++) begin
         a = (i < 16) ? tbl[i % 8] : 16'(rnd());
         w = (i < 16) ? i[3] : a[1];
         acc(w ? {a[15:1], 1'b0} : a, w);
      end
      cpu_req = 0;
      repeat (4) @(posedge ref_clk);
      `CHK(exp_q.size(), 0)
      `CHK(wr_q.size(), 0)
      wrap_up();
   end
   initial begin
      repeat (2000) @(posedge ref_clk);
      err_count++;
      wrap_up();
   end
endmodule : cpu_bus_cycle_control_tb
